// [pkg/lic_map.vh]
// Purpose: constants for the line interface host control block
// Assumes: ref_clk at 250 MHz, serial port clocked from the host
// Notes: status code fields are given as read-back bits [7:5]
// Notes on behaviour
// - control byte: length select bits 2..4, remote loop 5, local loop 6, all-ones 7
// - writing a one to a clear bit releases the interrupt; reads do not
// - while a clear bit is one, that source raises no interrupt
// - a write setting a clear bit also resets status code bits 5..7
// - writing zero to a clear bit re-enables that source
// - read-back gives driver failure at bit 1 and length select at 2..4
// - bits 5..7 encode config or changed-state conditions as listed
// - serial output is high impedance whenever it is not sending
// - edge select picks receive data edge and serial output edge
// - open-drain interrupt asserts on a state change of either alarm
// - serial input bits are captured on serial clock rising edge
// - local loop routes transmit clock and data to receive outputs
// - remote loop retransmits recovered signal and ignores all-ones
// - both loop controls high for 200 ns or more requests a reset
// - three-level mode input selects host, hardware or extended mode
// - extended mode ignores control pins while the pin gate is high
// - receive decoder select: low zero-substitution, high plain AMI
// - transmit encoder select: low zero-substitution, high plain AMI
// - all-ones sends marks at alternate clock rate; off if clock grounded
// - extended mode gives NRZ receive data valid on falling clock edge
// - write data follows in the eight clocks after the command byte
// - any reset clears all register bits and forces loss-of-signal high
`ifndef LIC_MAP_VH
`define LIC_MAP_VH
`define LIC_REF_CLK_PERIOD_NS 4
`define LIC_RST_REQ_NS        200
`define LIC_RST_REQ_CYC       ((`LIC_RST_REQ_NS + `LIC_REF_CLK_PERIOD_NS - 1) / `LIC_REF_CLK_PERIOD_NS)
`define LIC_CTRL_RESET        8'h00
`define LIC_BIT_SIGNAL_LOSS_CLEAR       0
`define LIC_BIT_DRIVER_FAIL_CLEAR       1
`define LIC_BIT_LEN_LO        2
`define LIC_BIT_LEN_HI        4
`define LIC_BIT_REMOTE_LOOP_REQ         5
`define LIC_BIT_LOCAL_LOOP_REQ         6
`define LIC_BIT_ALL_ONES_TX_REQ          7
`define LIC_CMD_ADDR          5'h10
`define LIC_CODE_NONE         3'h0
`define LIC_CODE_ALL_ONES_TX_REQ         3'h4
`define LIC_CODE_LOCAL_LOOP_REQ        3'h2
`define LIC_CODE_ALL_ONES_TX_REQ_LOCAL_LOOP_REQ   3'h6
`define LIC_CODE_REMOTE_LOOP_REQ        3'h1
`define LIC_CODE_DPM_CHG      3'h5
`define LIC_CODE_LOS_CHG      3'h3
`define LIC_CODE_BOTH_CHG     3'h7
`define LIC_CNT_CMD_LAST      5'h07
`define LIC_CNT_DATA_FIRST    5'h08
`define LIC_CNT_DATA_LAST     5'h0f
`define LIC_CNT_DONE          5'h10
`define LIC_MODE_HOST         2'h1
`define LIC_MODE_HW           2'h0
`define LIC_MODE_EXT          2'h2
`endif

// [src/lic_line_ctrl.v]
// Purpose: serial control register, alarms and loop routing of a line interface
// Assumes: every pin input other than rst_b is asynchronous to ref_clk and is synchronised here
// Notes: codec, clock recovery and alarm detectors sit outside; sclk must be well below ref_clk/4
`timescale 1ns/1ns
`default_nettype none
`include "lic_map.vh"
module lic_line_ctrl (
  input  wire       ref_clk,
  input  wire       rst_b,
  input  wire       sclk,
  input  wire       cs_n,
  input  wire       port_data_in,
  output reg        port_data_out,
  output reg        port_data_out_oe,
  output reg        int_n_out,
  output reg        int_n_oe,
  input  wire       edge_select,
  input  wire       mode_high,
  input  wire       mode_low,
  input  wire       pin_gate_n,
  input  wire [2:0] pin_line_length_sel,
  input  wire       pin_remote_loop_req,
  input  wire       pin_local_loop_req,
  input  wire       pin_all_ones_tx_req,
  input  wire       pin_rx_decoder_sel,
  input  wire       pin_tx_encoder_sel,
  input  wire       alt_ref_clock,
  input  wire       alt_clock_grounded,
  input  wire       signal_loss_det,
  input  wire       driver_fail_det,
  input  wire       tx_clk_in,
  input  wire       tx_pos_data,
  input  wire       tx_neg_data,
  input  wire       rec_clk_in,
  input  wire       rec_pos_in,
  input  wire       rec_neg_in,
  output reg        line_tx_clk,
  output reg        line_tx_pos,
  output reg        line_tx_neg,
  output reg        rx_clk_out,
  output reg        rx_pos_data,
  output reg        rx_neg_data,
  output reg        signal_loss_flag,
  output reg        driver_fail_flag,
  output reg  [2:0] line_length_sel,
  output reg        rx_decoder_sel,
  output reg        tx_encoder_sel,
  output reg  [1:0] mode_sel
);
  localparam NSYNC = 25;
  localparam I_SCLK = 0;
  localparam I_CSN = 1;
  localparam I_SDI = 2;
  localparam I_TXC = 3;
  localparam I_TXP = 4;
  localparam I_TXN = 5;
  localparam I_RCC = 6;
  localparam I_RCP = 7;
  localparam I_RCN = 8;
  localparam I_ALT = 9;
  localparam I_LOS = 10;
  localparam I_DPM = 11;
  localparam I_EDGE_SELECT = 12;
  localparam I_MHI = 13;
  localparam I_MLO = 14;
  localparam I_GATE = 15;
  localparam I_LEN = 16;
  localparam I_RLP = 19;
  localparam I_LLP = 20;
  localparam I_AOS = 21;
  localparam I_RCD = 22;
  localparam I_TCD = 23;
  localparam I_AGND = 24;
  localparam [31:0] RST_REQ_ALL = `LIC_RST_REQ_CYC;
  localparam [5:0]  RST_REQ_CYC = RST_REQ_ALL[5:0];
  // sync chain resets to idle pin levels: chip select high and loss high,
  // so leaving reset shows neither a false select edge nor a false alarm change
  localparam [NSYNC-1:0] SYNC_IDLE = (25'h000_0001 << I_CSN) | (25'h000_0001 << I_LOS);

  // status code, priority to pending changes over configuration
  function [2:0] lic_code;
    input pend_los;
    input pend_dpm;
    input remote_loop_req;
    input local_loop_req;
    input all_ones_tx_req;
    begin
      if (pend_los && pend_dpm) lic_code = `LIC_CODE_BOTH_CHG;
      else if (pend_los) lic_code = `LIC_CODE_LOS_CHG;
      else if (pend_dpm) lic_code = `LIC_CODE_DPM_CHG;
      else if (remote_loop_req) lic_code = `LIC_CODE_REMOTE_LOOP_REQ;
      else if (local_loop_req && all_ones_tx_req) lic_code = `LIC_CODE_ALL_ONES_TX_REQ_LOCAL_LOOP_REQ;
      else if (local_loop_req) lic_code = `LIC_CODE_LOCAL_LOOP_REQ;
      else if (all_ones_tx_req) lic_code = `LIC_CODE_ALL_ONES_TX_REQ;
      else lic_code = `LIC_CODE_NONE;
    end
  endfunction

  wire [NSYNC-1:0] async_in = {alt_clock_grounded, pin_tx_encoder_sel, pin_rx_decoder_sel,
                               pin_all_ones_tx_req, pin_local_loop_req, pin_remote_loop_req,
                               pin_line_length_sel, pin_gate_n, mode_low, mode_high,
                               edge_select, driver_fail_det, signal_loss_det, alt_ref_clock,
                               rec_neg_in, rec_pos_in, rec_clk_in, tx_neg_data, tx_pos_data,
                               tx_clk_in, port_data_in, cs_n, sclk};
  reg  [NSYNC-1:0] sync1_ff;
  reg  [NSYNC-1:0] sync2_ff;
  reg  [NSYNC-1:0] prev_ff;
  reg  [7:0]       ctrl_ff;
  reg  [7:0]       cmd_ff;
  reg  [7:0]       wdat_ff;
  reg  [7:0]       snap_ff;
  reg  [4:0]       cnt_ff;
  reg              active_ff;
  reg              rd_go_ff;
  reg              pend_los_ff;
  reg              pend_dpm_ff;
  reg  [7:0]       pin_cfg_ff;
  reg  [5:0]       req_cnt_ff;
  reg              req_armed_ff;
  reg              ao_pol_ff;
  reg              los_seen_ff;
  reg              dpm_seen_ff;

  wire [NSYNC-1:0] s = sync2_ff;
  wire sclk_rise = s[I_SCLK] & ~prev_ff[I_SCLK];
  wire sclk_fall = ~s[I_SCLK] & prev_ff[I_SCLK];
  wire cs_fall   = ~s[I_CSN] & prev_ff[I_CSN];

  // mode from the three-level comparator pair
  wire [1:0] mode = s[I_MHI] ? `LIC_MODE_HOST :
                    s[I_MLO] ? `LIC_MODE_HW : `LIC_MODE_EXT;
  wire is_host = (mode == `LIC_MODE_HOST);
  wire is_ext  = (mode == `LIC_MODE_EXT);

  // serial framing
  wire       take_bit = active_ff & sclk_rise & (cnt_ff < `LIC_CNT_DONE);
  wire [7:0] cmd_full = {s[I_SDI], cmd_ff[6:0]};
  wire       cmd_done = take_bit & (cnt_ff == `LIC_CNT_CMD_LAST);
  wire       cmd_hit  = (cmd_full[5:1] == `LIC_CMD_ADDR) & ~cmd_full[6];
  wire [7:0] wbyte    = {s[I_SDI], wdat_ff[6:0]};
  wire       commit   = take_bit & (cnt_ff == `LIC_CNT_DATA_LAST) & active_ff &
                        ~rd_go_ff & (cmd_ff[5:1] == `LIC_CMD_ADDR) & ~cmd_ff[6]
                        & ~cmd_ff[0] & is_host;
  wire       host_rst = commit & wbyte[`LIC_BIT_REMOTE_LOOP_REQ] & wbyte[`LIC_BIT_LOCAL_LOOP_REQ];

  // pin reset request: qualify length, fire on release
  wire pin_req  = ~is_host & s[I_RLP] & s[I_LLP];
  wire pin_rst  = req_armed_ff & ~pin_req;
  wire soft_rst = host_rst | pin_rst;

  // effective configuration
  wire [7:0] cfg      = is_host ? ctrl_ff : pin_cfg_ff;
  wire       remote_loop_req    = cfg[`LIC_BIT_REMOTE_LOOP_REQ];
  wire       local_loop_req    = cfg[`LIC_BIT_LOCAL_LOOP_REQ] & ~remote_loop_req;
  wire       ao_avail = ~s[I_AGND];
  wire       all_ones_tx_req_eff = cfg[`LIC_BIT_ALL_ONES_TX_REQ] & ~remote_loop_req & ao_avail;
  wire [7:0] pin_now  = {s[I_AOS], s[I_LLP], s[I_RLP], s[I_LEN+2:I_LEN], s[I_TCD], s[I_RCD]};

  // alarm changes
  wire los_chg = s[I_LOS] ^ los_seen_ff;
  wire dpm_chg = s[I_DPM] ^ dpm_seen_ff;
  wire signal_loss_clear = commit & wbyte[`LIC_BIT_SIGNAL_LOSS_CLEAR];
  wire driver_fail_clear = commit & wbyte[`LIC_BIT_DRIVER_FAIL_CLEAR];
  wire sup_los = ctrl_ff[`LIC_BIT_SIGNAL_LOSS_CLEAR] | signal_loss_clear;
  wire sup_dpm = ctrl_ff[`LIC_BIT_DRIVER_FAIL_CLEAR] | driver_fail_clear;

  wire [2:0] code = lic_code(pend_los_ff, pend_dpm_ff, remote_loop_req, local_loop_req, cfg[`LIC_BIT_ALL_ONES_TX_REQ]);
  wire [7:0] status = {code, ctrl_ff[`LIC_BIT_LEN_HI:`LIC_BIT_LEN_LO],
                       driver_fail_flag, signal_loss_flag};
  wire [4:0] rd_idx = cnt_ff - `LIC_CNT_DATA_FIRST;
  wire       rd_win = rd_go_ff & (cnt_ff >= `LIC_CNT_DATA_FIRST) & (cnt_ff <= `LIC_CNT_DATA_LAST);

  // receive side sources
  wire rsrc_clk  = local_loop_req ? s[I_TXC] : s[I_RCC];
  wire rsrc_prev = local_loop_req ? prev_ff[I_TXC] : prev_ff[I_RCC];
  wire rsrc_pos  = local_loop_req ? s[I_TXP] : s[I_RCP];
  wire rsrc_neg  = local_loop_req ? s[I_TXN] : s[I_RCN];
  // host picks the edge; hardware valid on rise, extended valid on fall
  wire upd_rise  = is_host ? s[I_EDGE_SELECT] : is_ext;
  wire rsrc_edge = upd_rise ? (rsrc_clk & ~rsrc_prev) : (~rsrc_clk & rsrc_prev);
  wire alt_rise  = s[I_ALT] & ~prev_ff[I_ALT];
  wire rec_rise  = s[I_RCC] & ~prev_ff[I_RCC];
  wire txc_fall  = ~s[I_TXC] & prev_ff[I_TXC];

  // prev_ff gives one cycle of history to every edge detector
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      sync1_ff <= SYNC_IDLE;
      sync2_ff <= SYNC_IDLE;
      prev_ff  <= SYNC_IDLE;
    end else begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // serial port and register
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      active_ff <= 1'b0;
      cnt_ff    <= 5'h00;
      cmd_ff    <= 8'h00;
      wdat_ff   <= 8'h00;
      snap_ff   <= 8'h00;
      rd_go_ff  <= 1'b0;
      ctrl_ff   <= `LIC_CTRL_RESET;
      port_data_out    <= 1'b0;
      port_data_out_oe <= 1'b0;
    end else begin
      if (cs_fall) begin
        active_ff <= 1'b1;
        cnt_ff    <= 5'h00;
        rd_go_ff  <= 1'b0;
      end else if (s[I_CSN]) begin
        active_ff <= 1'b0;
      end else if (take_bit) begin
        cnt_ff <= cnt_ff + 5'h01;
        if (cnt_ff < `LIC_CNT_DATA_FIRST)
          cmd_ff[cnt_ff[2:0]] <= s[I_SDI];
        else
          wdat_ff[cnt_ff[2:0]] <= s[I_SDI];
        if (cmd_done) begin
          rd_go_ff <= cmd_full[0] & cmd_hit & is_host;
          snap_ff  <= status;
        end
      end
      if (soft_rst)
        ctrl_ff <= `LIC_CTRL_RESET;
      else if (commit)
        ctrl_ff <= wbyte;
      // output only in the read window, otherwise released
      if (s[I_CSN] || !active_ff || !rd_go_ff) begin
        port_data_out_oe <= 1'b0;
      end else if (s[I_EDGE_SELECT] ? sclk_fall : sclk_rise) begin
        if (rd_win) begin
          port_data_out    <= snap_ff[rd_idx[2:0]];
          port_data_out_oe <= 1'b1;
        end else if (cnt_ff >= `LIC_CNT_DONE) begin
          port_data_out_oe <= 1'b0;
        end
      end
    end
  end

  // alarms, interrupt and pin control capture
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      pend_los_ff      <= 1'b0;
      pend_dpm_ff      <= 1'b0;
      los_seen_ff      <= 1'b1;
      dpm_seen_ff      <= 1'b0;
      signal_loss_flag <= 1'b1;
      driver_fail_flag <= 1'b0;
      int_n_out        <= 1'b0;
      int_n_oe         <= 1'b0;
      pin_cfg_ff       <= `LIC_CTRL_RESET;
      req_cnt_ff       <= 6'h00;
      req_armed_ff     <= 1'b0;
      mode_sel         <= `LIC_MODE_HW;
      line_length_sel  <= 3'h0;
      rx_decoder_sel   <= 1'b0;
      tx_encoder_sel   <= 1'b0;
    end else begin
      los_seen_ff      <= s[I_LOS];
      dpm_seen_ff      <= s[I_DPM];
      signal_loss_flag <= soft_rst | s[I_LOS];
      driver_fail_flag <= s[I_DPM];
      // a change and its clear in one cycle: the change is suppressed by that clear
      if (soft_rst)
        pend_los_ff <= 1'b0;
      else if (is_host && los_chg && !sup_los)
        pend_los_ff <= 1'b1;
      else if (signal_loss_clear)
        pend_los_ff <= 1'b0;
      if (soft_rst)
        pend_dpm_ff <= 1'b0;
      else if (is_host && dpm_chg && !sup_dpm)
        pend_dpm_ff <= 1'b1;
      else if (driver_fail_clear)
        pend_dpm_ff <= 1'b0;
      int_n_oe <= is_host & (pend_los_ff | pend_dpm_ff);
      if (soft_rst)
        pin_cfg_ff <= `LIC_CTRL_RESET;
      else if (!is_ext || !s[I_GATE])
        pin_cfg_ff <= pin_now;
      if (pin_req) begin
        if (req_cnt_ff != RST_REQ_CYC)
          req_cnt_ff <= req_cnt_ff + 6'h01;
        else
          req_armed_ff <= 1'b1;
      end else begin
        req_cnt_ff   <= 6'h00;
        req_armed_ff <= 1'b0;
      end
      mode_sel        <= mode;
      line_length_sel <= cfg[`LIC_BIT_LEN_HI:`LIC_BIT_LEN_LO];
      // pin bits 0,1 carry the code selects; host mode always uses plain AMI pins
      rx_decoder_sel  <= is_ext ? cfg[0] : 1'b1;
      tx_encoder_sel  <= is_ext ? cfg[1] : 1'b1;
    end
  end

  // line datapath
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      line_tx_clk <= 1'b0;
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
      rx_clk_out  <= 1'b0;
      rx_pos_data <= 1'b0;
      rx_neg_data <= 1'b0;
      ao_pol_ff   <= 1'b0;
    end else begin
      rx_clk_out <= rsrc_clk;
      if (rsrc_edge) begin
        rx_pos_data <= is_ext ? (rsrc_pos | rsrc_neg) : rsrc_pos;
        rx_neg_data <= is_ext ? 1'b0 : rsrc_neg;
      end
      if (remote_loop_req) begin
        line_tx_clk <= s[I_RCC];
        if (rec_rise) begin
          line_tx_pos <= s[I_RCP];
          line_tx_neg <= s[I_RCN];
        end
      end else if (all_ones_tx_req_eff) begin
        line_tx_clk <= s[I_ALT];
        if (alt_rise) begin
          ao_pol_ff   <= ~ao_pol_ff;
          line_tx_pos <= ao_pol_ff;
          line_tx_neg <= ~ao_pol_ff;
        end
      end else begin
        line_tx_clk <= s[I_TXC];
        if (txc_fall) begin
          line_tx_pos <= s[I_TXP];
          line_tx_neg <= s[I_TXN];
        end
      end
    end
  end
endmodule // lic_line_ctrl
`default_nettype wire

// [bench/lic_host.sv]
// Purpose: host model driving the serial control port
// Assumes: sclk stands low outside frames, 125 ns period
// Notes: a released data line shows the inverse of its last bit
`timescale 1ns/1ns
`default_nettype none
module lic_host (
  output logic      sclk,
  output logic      cs_n,
  output logic      port_data_in,
  input  wire logic port_data_out,
  input  wire logic port_data_out_oe,
  input  wire logic edge_select
);
  // z when not driven, so a silent port never matches a value
  wire seen = port_data_out_oe ? port_data_out : 1'bz;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    port_data_in = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] bits;
    bits = {wd, cmd};
    // nonblocking, so a change that lands on a ref_clk edge is seen after it
    cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      port_data_in <= bits[i];
      #62;
      if (edge_select && i > 7) rd[i-8] = seen;
      sclk <= 1'b1;
      #63;
      if (!edge_select && i > 7) rd[i-8] = seen;
      sclk <= 1'b0;
    end
    #63;
    cs_n <= 1'b1;
    port_data_in <= ~port_data_in;
    #250;
  endtask
endmodule  // lic_host
`default_nettype wire

// [bench/lic_line_ctrl_chk.sv]
// Purpose: port checks for the line interface control block
// Assumes: ports only, one clock domain
// Notes: windows allow for the input sync latency
`timescale 1ns/1ns
`default_nettype none
`include "lic_map.vh"
module lic_chk (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       cs_n,
  input wire logic       port_data_out_oe,
  input wire logic       int_n_out,
  input wire logic       int_n_oe,
  input wire logic       mode_high,
  input wire logic       mode_low,
  input wire logic       pin_gate_n,
  input wire logic       signal_loss_flag,
  input wire logic       driver_fail_flag,
  input wire logic [2:0] line_length_sel,
  input wire logic       rx_decoder_sel,
  input wire logic       tx_encoder_sel,
  input wire logic [1:0] mode_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_reset_values: assert property (
    $rose(rst_b) |-> signal_loss_flag && !int_n_oe && !port_data_out_oe)
    else $error("reset values wrong");
  chk_idle_quiet: assert property (cs_n [*8] |-> !port_data_out_oe)
    else $error("serial out driven while deselected");
  chk_drive_in_frame: assert property ($rose(port_data_out_oe) |-> !cs_n)
    else $error("serial out driven outside a frame");
  chk_int_drain: assert property (int_n_oe |-> !int_n_out)
    else $error("interrupt pin not pulled low");
  chk_int_cause: assert property ($rose(int_n_oe) |->
    signal_loss_flag != $past(signal_loss_flag, 4) || driver_fail_flag != $past(driver_fail_flag, 4))
    else $error("interrupt without alarm change");
  chk_mode_host: assert property (mode_high [*6] |-> mode_sel == `LIC_MODE_HOST)
    else $error("host mode not selected");
  chk_mode_ext: assert property (
    (!mode_high && !mode_low) [*6] |-> mode_sel == `LIC_MODE_EXT)
    else $error("extended mode not selected");
  chk_gate_hold: assert property (
    (!mode_high && !mode_low && pin_gate_n) [*8] |-> $stable(line_length_sel))
    else $error("length moved while gate shut");
  chk_host_codec: assert property (
    (mode_sel == `LIC_MODE_HOST) [*4] |-> rx_decoder_sel && tx_encoder_sel)
    else $error("codec selects wrong in host mode");
endmodule  // lic_chk
bind lic_line_ctrl lic_chk i_lic_chk (
  .ref_clk, .rst_b, .cs_n, .port_data_out_oe, .int_n_out, .int_n_oe, .mode_high,
  .mode_low, .pin_gate_n, .signal_loss_flag, .driver_fail_flag, .line_length_sel,
  .rx_decoder_sel, .tx_encoder_sel, .mode_sel
);
`default_nettype wire

// [bench/tb.sv]
// Purpose: self-checking bench for the line interface control block
// Assumes: host mode unless a test says otherwise
// Notes: loss detector starts high so release of reset is no alarm change
`timescale 1ns/1ns
`default_nettype none
`include "lic_map.vh"
module tb;
  logic       ref_clk = 1'b0, rst_b = 1'b0, edge_select = 1'b1;
  logic       mode_high = 1'b1, mode_low = 1'b0, pin_gate_n = 1'b1;
  logic [2:0] pin_line_length_sel = 3'h0;
  logic       pin_remote_loop_req = 1'b0, pin_local_loop_req = 1'b0;
  logic       pin_all_ones_tx_req = 1'b0, pin_rx_decoder_sel = 1'b0;
  logic       pin_tx_encoder_sel = 1'b0, alt_clock_grounded = 1'b0;
  logic       signal_loss_det = 1'b1, driver_fail_det = 1'b0;
  logic       tx_pos_data = 1'b1, rec_pos_in = 1'b0;
  logic [7:0] ck_cnt = 8'h00;
  logic [7:0] rd;
  int         fail_count = 0;
  int         samples_checked = 0;
  wire        sclk, cs_n, port_data_in, port_data_out, port_data_out_oe;
  wire        int_n_out, int_n_oe, line_tx_pos, line_tx_neg, rx_pos_data;
  wire        signal_loss_flag, driver_fail_flag, rx_decoder_sel, tx_encoder_sel;
  wire  [2:0] line_length_sel;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) ck_cnt <= ck_cnt + 8'h01;
  lic_line_ctrl i_lic_line_ctrl (
    .ref_clk, .rst_b, .sclk, .cs_n, .port_data_in, .port_data_out, .port_data_out_oe,
    .int_n_out, .int_n_oe, .edge_select, .mode_high, .mode_low, .pin_gate_n,
    .pin_line_length_sel, .pin_remote_loop_req, .pin_local_loop_req, .pin_all_ones_tx_req,
    .pin_rx_decoder_sel, .pin_tx_encoder_sel, .alt_ref_clock(ck_cnt[3]), .alt_clock_grounded,
    .signal_loss_det, .driver_fail_det, .tx_clk_in(ck_cnt[5]), .tx_pos_data,
    .tx_neg_data(1'b0), .rec_clk_in(ck_cnt[5]), .rec_pos_in, .rec_neg_in(1'b0),
    .line_tx_clk(), .line_tx_pos, .line_tx_neg, .rx_clk_out(), .rx_pos_data,
    .rx_neg_data(), .signal_loss_flag, .driver_fail_flag, .line_length_sel,
    .rx_decoder_sel, .tx_encoder_sel, .mode_sel()
  );
  lic_host i_lic_host (.sclk, .cs_n, .port_data_in, .port_data_out, .port_data_out_oe,
    .edge_select);
  task automatic test_done;
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] d);
    i_lic_host.xfer(8'h20, d, rd);
  endtask
  task automatic rdb(input logic [7:0] exp, input string what);
    i_lic_host.xfer(8'h21, 8'h00, rd);
    cmp8(what, exp, rd);
  endtask
  task automatic wait_int;
    for (int i = 0; i < 40 && int_n_oe !== 1'b1; i++) @(posedge ref_clk);
  endtask
  task automatic t_reset;
    cmp8("int idle", 8'h00, {7'h00, int_n_oe});
    rdb(8'h01, "reset status");
  endtask
  task automatic t_codes;
    logic [7:0] ctl [5] = '{8'h00, 8'h80, 8'h40, 8'hc0, 8'h20};
    logic [2:0] code [5] = '{`LIC_CODE_NONE, `LIC_CODE_ALL_ONES_TX_REQ, `LIC_CODE_LOCAL_LOOP_REQ,
                             `LIC_CODE_ALL_ONES_TX_REQ_LOCAL_LOOP_REQ, `LIC_CODE_REMOTE_LOOP_REQ};
    logic [2:0] len;
    logic [1:0] line_seen;
    for (int i = 0; i < 5; i++) begin
      len = 3'(i * 7);
      @(posedge ref_clk);
      edge_select <= i[0];
      wr(ctl[i] | {3'h0, len, 2'h0});
      rdb({code[i], len, 2'h1}, "status code");
      cmp8("length out", {5'h00, len}, {5'h00, line_length_sel});
      if (i == 0) cmp8("plain path", 8'h01, {6'h00, rx_pos_data, line_tx_pos});
      if (i == 1) begin
        tick(1);
        line_seen = {line_tx_pos, line_tx_neg};
        tick(16);
        cmp8("all ones", {6'h00, ~line_seen}, {6'h00, line_tx_pos, line_tx_neg});
      end
      if (i == 2) cmp8("local loop", 8'h03, {6'h00, rx_pos_data, line_tx_pos});
      if (i == 3) begin
        alt_clock_grounded <= 1'b1;
        tick(80);
        cmp8("all_ones_tx_req grounded", 8'h02, {6'h00, line_tx_pos, line_tx_neg});
        tick(16);
        cmp8("all_ones_tx_req grounded", 8'h02, {6'h00, line_tx_pos, line_tx_neg});
        alt_clock_grounded <= 1'b0;
      end
      if (i == 4) cmp8("remote loop", 8'h00, {6'h00, rx_pos_data, line_tx_pos});
    end
  endtask
  task automatic t_int;
    wr(8'h00);
    driver_fail_det <= 1'b1;
    wait_int;
    cmp8("drv interrupt", 8'h01, {7'h00, int_n_oe});
    rdb({`LIC_CODE_DPM_CHG, 3'h0, 2'h3}, "drv change");
    rdb({`LIC_CODE_DPM_CHG, 3'h0, 2'h3}, "read again");
    cmp8("int after read", 8'h01, {7'h00, int_n_oe});
    signal_loss_det <= 1'b0;
    tick(40);
    rdb({`LIC_CODE_BOTH_CHG, 3'h0, 2'h2}, "both change");
    wr(8'h03);
    cmp8("int cleared", 8'h00, {7'h00, int_n_oe});
    rdb({`LIC_CODE_NONE, 3'h0, 2'h2}, "code cleared");
    driver_fail_det <= 1'b0;
    tick(40);
    cmp8("suppressed", 8'h00, {7'h00, int_n_oe});
    wr(8'h00);
    signal_loss_det <= 1'b1;
    wait_int;
    cmp8("re-enabled", 8'h01, {7'h00, int_n_oe});
  endtask
  task automatic t_refuse;
    i_lic_host.xfer(8'h22, 8'h1c, rd);
    i_lic_host.xfer(8'h60, 8'h1c, rd);
    i_lic_host.xfer(8'h23, 8'h00, rd);
    cmp8("bad read", 8'hzz, rd);
    rdb({`LIC_CODE_LOS_CHG, 3'h0, 2'h1}, "after refusals");
  endtask
  task automatic t_softrst;
    wr(8'h7c);
    rdb(8'h01, "soft reset");
    cmp8("reset outs", 8'h00, {4'h0, int_n_oe, line_length_sel});
  endtask
  task automatic t_ext;
    mode_high <= 1'b0;
    pin_gate_n <= 1'b0;
    pin_line_length_sel <= 3'h6;
    pin_tx_encoder_sel <= 1'b1;
    tick(10);
    cmp8("gate open", 8'h19, {3'h0, line_length_sel, rx_decoder_sel, tx_encoder_sel});
    pin_gate_n <= 1'b1;
    tick(2);
    pin_line_length_sel <= 3'h1;
    pin_rx_decoder_sel <= 1'b1;
    tick(10);
    cmp8("gate shut", 8'h19, {3'h0, line_length_sel, rx_decoder_sel, tx_encoder_sel});
    mode_high <= 1'b1;
    tick(10);
  endtask
  initial begin
    tick(16);
    rst_b <= 1'b1;
    tick(8);
    t_reset;
    t_codes;
    t_int;
    t_refuse;
    t_softrst;
    t_ext;
    test_done;
  end
  initial begin
    #200000;
    fail_count++;
    test_done;
  end
endmodule  // tb
`default_nettype wire
